/* verilog/rpe_pkg.sv */
// Purpose: Shared constants for the receive-port equalizer control block
// Assumes: 8-bit register port, 100 MHz core clock
// Notes:   Offsets are byte addresses of the register port
`default_nettype none

package rpe_pkg;
   // Register offsets
   localparam logic [7:0] ADDR_PORT_SEL = 8'h4c; // Port select
   localparam logic [7:0] ADDR_RSVD_BD  = 8'hbd; // Reserved
   localparam logic [7:0] ADDR_PULLDOWN = 8'hbe; // Pin pulldown disable
   localparam logic [7:0] ADDR_RSVD_BF  = 8'hbf; // Reserved
   localparam logic [7:0] ADDR_ERR_INJ  = 8'hd0; // Error injection
   localparam logic [7:0] ADDR_RSVD_D1  = 8'hd1; // Reserved
   localparam logic [7:0] ADDR_SEQ_CTL  = 8'hd2; // Sequencing control
   localparam logic [7:0] ADDR_EQ_STAT  = 8'hd3; // Setting status
   localparam logic [7:0] ADDR_MANUAL   = 8'hd4; // Manual override
   localparam logic [7:0] ADDR_LIMITS   = 8'hd5; // Ceiling and floor

   // Field positions
   localparam int SEQ_RELOCK_LSB  = 5; // Relock wait select [7:5]
   localparam int SEQ_FIRST_BIT   = 4; // First lock restart mode
   localparam int SEQ_RESTART_BIT = 3; // Adaptation restart
   localparam int SEQ_FLOOR_BIT   = 2; // Floor start enable
   localparam int MAN_UPPER_LSB   = 5; // Manual setting upper [7:5]
   localparam int MAN_MODE_BIT    = 4; // Lock requires adaptation
   localparam int MAN_LOWER_LSB   = 1; // Manual setting lower [3:1]
   localparam int MAN_BYPASS_BIT  = 0; // Manual equalizer select
   localparam int LIM_CEIL_LSB    = 4; // Ceiling [7:4], floor [3:0]
   localparam int INJ_CONT_BIT    = 1; // Continuous error inject
   localparam int INJ_ONE_BIT     = 0; // Single error inject

   // Reset values
   localparam logic [2:0] RST_RELOCK    = 3'h4;
   localparam logic       RST_FIRST     = 1'b1;
   localparam logic       RST_FLOOR_EN  = 1'b1;
   localparam logic [2:0] RST_UPPER     = 3'h3;
   localparam logic       RST_LOCK_MODE = 1'b0;
   localparam logic [2:0] RST_LOWER     = 3'h0;
   localparam logic       RST_BYPASS    = 1'b0;
   localparam logic [3:0] RST_CEIL      = 4'hf;
   localparam logic [3:0] RST_FLOOR     = 4'h2;
   localparam logic [7:0] RST_RSVD_D1   = 8'h43;

   // Timing: shortest relock wait, doubled per code step
   localparam int CLK_PERIOD_NS   = 10;
   localparam int RELOCK_BASE_NS  = 164000;
   localparam int RELOCK_BASE_CYC = RELOCK_BASE_NS / CLK_PERIOD_NS;
   localparam int TIMER_W         = 24; // Holds base count shifted by 7

   // Sequencer states
   typedef enum logic [2:0] {
      SEQ_ADAPT  = 3'b001,
      SEQ_DONE   = 3'b010,
      SEQ_MANUAL = 3'b100
   } rpe_seq_t;
endpackage

`default_nettype wire

/* verilog/rpe_eq_seq.sv */
// Purpose: Per-port equalizer sequencer and back channel error injector
// Assumes: raw_lock and bc_frame synchronous to clk
// Notes:   All outputs are registered
`default_nettype none

module rpe_eq_seq #(
   parameter int unsigned RELOCK_CYC = rpe_pkg::RELOCK_BASE_CYC
) (
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic [2:0] relock_sel,
   input  wire logic       first_lock_mode,
   input  wire logic       restart,
   input  wire logic       floor_en,
   input  wire logic [3:0] floor_val,
   input  wire logic [3:0] ceiling,
   input  wire logic       bypass,
   input  wire logic [5:0] manual,
   input  wire logic       lock_mode,
   input  wire logic       raw_lock,
   input  wire logic       bc_frame,
   input  wire logic       inj_cont,
   input  wire logic       inj_arm,
   output logic      [5:0] eq_q,
   output logic            lock_q,
   output logic            inj_q
);
   localparam int TW = rpe_pkg::TIMER_W;

   rpe_pkg::rpe_seq_t state_q;      // Sequencer state
   logic [TW-1:0]     timer_q;      // Relock wait counter
   logic [TW-1:0]     limit;        // Wait length for this code
   logic              expire;       // Wait ran out this cycle
   logic              first_seen_q; // Initial lock already seen
   logic              armed_q;      // Single injection pending
   logic [5:0]        start_val;    // Adaptation start point
   logic [2:0]        sel_q;        // Relock code the timer runs on
   logic              raw_q;        // Detector level one cycle back

   // Wait doubles with each code step
   assign limit = TW'(RELOCK_CYC) << sel_q;
   assign expire = (timer_q == limit - TW'(1));
   assign start_val = floor_en ? {2'b00, floor_val} : 6'h00;

   // Adaptation stepping, restart and manual override
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= rpe_pkg::SEQ_ADAPT;
         eq_q    <= 6'h00;
         timer_q <= '0;
      end else if (bypass) begin
         // Manual setting replaces adaptation
         state_q <= rpe_pkg::SEQ_MANUAL;
         eq_q    <= manual;
         timer_q <= '0;
      end else if (restart || state_q == rpe_pkg::SEQ_MANUAL) begin
         state_q <= rpe_pkg::SEQ_ADAPT;
         eq_q    <= start_val;
         timer_q <= '0;
      end else if (raw_lock && !first_seen_q && first_lock_mode) begin
         // Deterministic start: back to zero at first lock
         state_q <= rpe_pkg::SEQ_ADAPT;
         eq_q    <= 6'h00;
         timer_q <= '0;
      end else begin
         case (state_q)
            rpe_pkg::SEQ_ADAPT: begin
               if (raw_lock) begin
                  state_q <= rpe_pkg::SEQ_DONE;
                  timer_q <= '0;
               end else if (relock_sel != sel_q) begin
                  // New code: start the wait over so it cannot overrun
                  timer_q <= '0;
               end else if (expire) begin
                  timer_q <= '0;
                  if (eq_q < {2'b00, ceiling}) begin
                     eq_q <= eq_q + 6'h01;
                  end else begin
                     state_q <= rpe_pkg::SEQ_DONE;
                  end
               end else begin
                  timer_q <= timer_q + TW'(1);
               end
            end
            rpe_pkg::SEQ_DONE: begin
               // Lost lock: search again; a stop at the ceiling stays
               if (!raw_lock && raw_q) begin
                  state_q <= rpe_pkg::SEQ_ADAPT;
                  eq_q    <= start_val;
               end
            end
            default: state_q <= rpe_pkg::SEQ_ADAPT;
         endcase
      end
   end

   // Remember the initial lock; a lock in the clearing cycle wins
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) first_seen_q <= 1'b0;
      else if (raw_lock) first_seen_q <= 1'b1;
      else if (restart || bypass) first_seen_q <= 1'b0;
   end

   // Code and detector history for the wait and loss checks
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sel_q <= rpe_pkg::RST_RELOCK;
         raw_q <= 1'b0;
      end else begin
         sel_q <= relock_sel;
         raw_q <= raw_lock;
      end
   end

   // Reported lock, optionally qualified by finished adaptation
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) lock_q <= 1'b0;
      else if (lock_mode)
         lock_q <= raw_lock && state_q == rpe_pkg::SEQ_DONE;
      else lock_q <= raw_lock;
   end

   // Back channel corruption; a new arm wins over the consuming frame
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         armed_q <= 1'b0;
         inj_q   <= 1'b0;
      end else begin
         inj_q <= bc_frame && (inj_cont || armed_q);
         if (inj_arm) armed_q <= 1'b1;
         else if (bc_frame) armed_q <= 1'b0;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_wait_bound: assert property (
      state_q == rpe_pkg::SEQ_ADAPT |-> timer_q < limit)
      else $error("relock timer beyond limit");
   a_first_zero: assert property (
      first_lock_mode && raw_lock && !first_seen_q && !bypass
      && !restart && state_q != rpe_pkg::SEQ_MANUAL
      |=> eq_q == 6'h00)
      else $error("first lock did not restart at zero");
   a_accept_lock: assert property (
      !first_lock_mode && raw_lock && !bypass && !restart
      && state_q == rpe_pkg::SEQ_ADAPT
      |=> state_q == rpe_pkg::SEQ_DONE && $stable(eq_q))
      else $error("lock not accepted at current value");
   a_floor_start: assert property (
      restart && !bypass && floor_en
      |=> eq_q == {2'b00, $past(floor_val)})
      else $error("restart ignored floor");
   a_manual_use: assert property (
      bypass |=> eq_q == $past(manual) ##1 eq_q == $past(manual)
      || !$past(bypass))
      else $error("manual setting not applied");
   a_lock_qual: assert property (
      lock_mode && state_q != rpe_pkg::SEQ_DONE |=> !lock_q)
      else $error("lock reported before adaptation done");
   a_lock_raw: assert property (
      !lock_mode |=> lock_q == $past(raw_lock))
      else $error("lock not taken from detector");
   a_cont_inject: assert property (
      inj_cont && bc_frame |=> inj_q)
      else $error("continuous injection missed frame");
   a_one_inject: assert property (
      bc_frame && armed_q && !inj_arm |=> inj_q ##1 !armed_q
      || $past(inj_arm))
      else $error("single injection not consumed");
   a_step_ceiling: assert property (
      state_q == rpe_pkg::SEQ_ADAPT && expire && !raw_lock
      && !bypass && !restart && eq_q >= {2'b00, ceiling}
      |=> state_q == rpe_pkg::SEQ_DONE)
      else $error("adaptation passed ceiling");

   c_step: cover property (state_q == rpe_pkg::SEQ_ADAPT && expire);
   c_done: cover property (state_q == rpe_pkg::SEQ_DONE && lock_q);
   c_inject: cover property (inj_q && !inj_cont);
   c_manual: cover property (state_q == rpe_pkg::SEQ_MANUAL);
endmodule

`default_nettype wire

/* verilog/rpe_ctrl.sv */
// Purpose: Receive-port equalizer control and pin pulldown registers
// Assumes: Byte register port driven by the serial control slave
// Notes:   Per-port registers are reached through the port select
//
// Behaviour
// - Relock wait code doubles from 164 us
// - First lock restarts adaptation from zero
// - Mode clear accepts lock at any value
// - Restart bit restarts adaptation, reads zero
// - Floor enable starts adaptation at floor; after reset the code starts at zero
// - Upper manual bits used only in bypass
// - Lock mode one waits for adaptation
// - Lock mode zero uses detector alone
// - Continuous bit corrupts every back frame
// - Single bit corrupts exactly one frame
// - Pulldown on when pin not output
// - Disable bit keeps pulldown off
// - Port select routes per-port accesses
// - Lower manual bits plus bypass select
// - Ceiling bounds adaptation, resets to 0xF
// - Floor field gives start, resets 0x2
`default_nettype none

module rpe_ctrl #(
   parameter int          NUM_PORTS       = 2,
   parameter int          NUM_PINS        = 7,
   parameter int unsigned RELOCK_BASE_CYC = rpe_pkg::RELOCK_BASE_CYC
) (
   input  wire logic                   CORE_CLK,
   input  wire logic                   RESET_N,
   input  wire logic [7:0]             REG_ADDR,
   input  wire logic [7:0]             REG_WDATA,
   input  wire logic                   REG_WR,
   input  wire logic                   REG_RD,
   output logic      [7:0]             REG_RDATA,
   input  wire logic [NUM_PORTS-1:0]   RX_LOCK_RAW,
   input  wire logic [NUM_PORTS-1:0]   BC_FRAME,
   input  wire logic [NUM_PINS-1:0]    PIN_OUTPUT_MODE,
   output logic      [6*NUM_PORTS-1:0] EQ_SETTING,
   output logic      [NUM_PORTS-1:0]   RX_LOCK,
   output logic      [NUM_PORTS-1:0]   BC_ERR_INJECT,
   output logic      [NUM_PINS-1:0]    PULLDOWN_EN
);
   localparam int PSEL_W = (NUM_PORTS > 1) ? $clog2(NUM_PORTS) : 1;

   // Global state
   logic [PSEL_W-1:0]   port_sel_q; // Selected receive port
   logic [NUM_PINS-1:0] pd_dis_q;   // Pulldown disable bits
   logic [7:0]          rd_d;       // Read mux output

   // Per-port register copies
   logic [2:0] relock_q    [NUM_PORTS]; // Relock wait select
   logic       first_q     [NUM_PORTS]; // First lock restart mode
   logic       floor_en_q  [NUM_PORTS]; // Floor start enable
   logic       restart_q   [NUM_PORTS]; // Restart pulse
   logic [2:0] upper_q     [NUM_PORTS]; // Manual setting upper
   logic       lock_mode_q [NUM_PORTS]; // Lock requires adaptation
   logic [2:0] lower_q     [NUM_PORTS]; // Manual setting lower
   logic       bypass_q    [NUM_PORTS]; // Manual equalizer select
   logic [3:0] ceil_q      [NUM_PORTS]; // Adaptation ceiling
   logic [3:0] floor_q     [NUM_PORTS]; // Adaptation floor setting
   logic       inj_cont_q  [NUM_PORTS]; // Continuous error inject
   logic       inj_one_q   [NUM_PORTS]; // Single error inject
   logic       arm_q       [NUM_PORTS]; // Single inject arm pulse
   logic [5:0] eq_w        [NUM_PORTS]; // Current setting per port

   // Write hit on a global offset
   function automatic logic wr_at(input logic [7:0] a);
      return REG_WR && REG_ADDR == a;
   endfunction

   // Port select register
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         port_sel_q <= '0;
      end else if (wr_at(rpe_pkg::ADDR_PORT_SEL)) begin
         port_sel_q <= REG_WDATA[PSEL_W-1:0];
      end
   end

   // Pulldown disable bits; bit 7 reads zero
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         pd_dis_q <= '0;
      end else if (wr_at(rpe_pkg::ADDR_PULLDOWN)) begin
         pd_dis_q <= REG_WDATA[NUM_PINS-1:0];
      end
   end

   // Pulldown drive: automatic unless disabled or pin drives out
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         // Pins come up as inputs, so pulldowns start on
         PULLDOWN_EN <= '1;
      end else begin
         PULLDOWN_EN <= ~PIN_OUTPUT_MODE & ~pd_dis_q;
      end
   end

   // Per-port registers and sequencers
   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
      logic wr_here; // Write reaching this port's copy

      // Only the selected port takes per-port writes
      assign wr_here = REG_WR && port_sel_q == PSEL_W'(p);

      // Sequencing control; restart is a one-cycle pulse
      always_ff @(posedge CORE_CLK or negedge RESET_N) begin
         if (!RESET_N) begin
            relock_q[p]   <= rpe_pkg::RST_RELOCK;
            first_q[p]    <= rpe_pkg::RST_FIRST;
            floor_en_q[p] <= rpe_pkg::RST_FLOOR_EN;
            restart_q[p]  <= 1'b0;
         end else begin
            restart_q[p] <= 1'b0;
            if (wr_here && REG_ADDR == rpe_pkg::ADDR_SEQ_CTL) begin
               relock_q[p] <=
                  REG_WDATA[rpe_pkg::SEQ_RELOCK_LSB +: 3];
               first_q[p] <= REG_WDATA[rpe_pkg::SEQ_FIRST_BIT];
               floor_en_q[p] <= REG_WDATA[rpe_pkg::SEQ_FLOOR_BIT];
               // Self clearing: never stored, only pulsed
               restart_q[p] <= REG_WDATA[rpe_pkg::SEQ_RESTART_BIT];
            end
         end
      end

      // Manual override and lock qualification
      always_ff @(posedge CORE_CLK or negedge RESET_N) begin
         if (!RESET_N) begin
            upper_q[p]     <= rpe_pkg::RST_UPPER;
            lock_mode_q[p] <= rpe_pkg::RST_LOCK_MODE;
            lower_q[p]     <= rpe_pkg::RST_LOWER;
            bypass_q[p]    <= rpe_pkg::RST_BYPASS;
         end else if (wr_here && REG_ADDR == rpe_pkg::ADDR_MANUAL) begin
            upper_q[p]     <= REG_WDATA[rpe_pkg::MAN_UPPER_LSB +: 3];
            lock_mode_q[p] <= REG_WDATA[rpe_pkg::MAN_MODE_BIT];
            lower_q[p]     <= REG_WDATA[rpe_pkg::MAN_LOWER_LSB +: 3];
            bypass_q[p]    <= REG_WDATA[rpe_pkg::MAN_BYPASS_BIT];
         end
      end

      // Ceiling and floor; ordering is software's duty
      always_ff @(posedge CORE_CLK or negedge RESET_N) begin
         if (!RESET_N) begin
            ceil_q[p]  <= rpe_pkg::RST_CEIL;
            floor_q[p] <= rpe_pkg::RST_FLOOR;
         end else if (wr_here && REG_ADDR == rpe_pkg::ADDR_LIMITS) begin
            ceil_q[p]  <= REG_WDATA[rpe_pkg::LIM_CEIL_LSB +: 4];
            floor_q[p] <= REG_WDATA[3:0];
         end
      end

      // Error injection bits; each write of a one arms once
      always_ff @(posedge CORE_CLK or negedge RESET_N) begin
         if (!RESET_N) begin
            inj_cont_q[p] <= 1'b0;
            inj_one_q[p]  <= 1'b0;
            arm_q[p]      <= 1'b0;
         end else begin
            arm_q[p] <= 1'b0;
            if (wr_here && REG_ADDR == rpe_pkg::ADDR_ERR_INJ) begin
               inj_cont_q[p] <= REG_WDATA[rpe_pkg::INJ_CONT_BIT];
               inj_one_q[p]  <= REG_WDATA[rpe_pkg::INJ_ONE_BIT];
               arm_q[p]      <= REG_WDATA[rpe_pkg::INJ_ONE_BIT];
            end
         end
      end

      // Sequencer; its outputs are flops and feed the pins directly
      rpe_eq_seq #(
         .RELOCK_CYC (RELOCK_BASE_CYC)
      ) u_seq (
         .clk             (CORE_CLK),
         .reset_n         (RESET_N),
         .relock_sel      (relock_q[p]),
         .first_lock_mode (first_q[p]),
         .restart         (restart_q[p]),
         .floor_en        (floor_en_q[p]),
         .floor_val       (floor_q[p]),
         .ceiling         (ceil_q[p]),
         .bypass          (bypass_q[p]),
         .manual          ({upper_q[p], lower_q[p]}),
         .lock_mode       (lock_mode_q[p]),
         .raw_lock        (RX_LOCK_RAW[p]),
         .bc_frame        (BC_FRAME[p]),
         .inj_cont        (inj_cont_q[p]),
         .inj_arm         (arm_q[p]),
         .eq_q            (eq_w[p]),
         .lock_q          (RX_LOCK[p]),
         .inj_q           (BC_ERR_INJECT[p])
      );

      assign EQ_SETTING[6*p +: 6] = eq_w[p];

      // Writes aimed at another port leave this copy alone
      a_port_route: assert property (@(posedge CORE_CLK)
         disable iff (!RESET_N)
         REG_WR && REG_ADDR == rpe_pkg::ADDR_SEQ_CTL
         && port_sel_q != PSEL_W'(p)
         |=> $stable(relock_q[p]) && !restart_q[p])
         else $error("write leaked to unselected port");
   end

   // Read mux over the selected port
   always_comb begin
      rd_d = 8'h00;
      case (REG_ADDR)
         rpe_pkg::ADDR_PORT_SEL: begin
            rd_d[PSEL_W-1:0] = port_sel_q;
         end
         rpe_pkg::ADDR_PULLDOWN: begin
            rd_d[NUM_PINS-1:0] = pd_dis_q;
         end
         rpe_pkg::ADDR_RSVD_D1: begin
            rd_d = rpe_pkg::RST_RSVD_D1;
         end
         rpe_pkg::ADDR_ERR_INJ: begin
            rd_d[rpe_pkg::INJ_CONT_BIT] = inj_cont_q[port_sel_q];
            rd_d[rpe_pkg::INJ_ONE_BIT]  = inj_one_q[port_sel_q];
         end
         rpe_pkg::ADDR_SEQ_CTL: begin
            // Restart bit always reads zero
            rd_d[rpe_pkg::SEQ_RELOCK_LSB +: 3] = relock_q[port_sel_q];
            rd_d[rpe_pkg::SEQ_FIRST_BIT] = first_q[port_sel_q];
            rd_d[rpe_pkg::SEQ_FLOOR_BIT] = floor_en_q[port_sel_q];
         end
         rpe_pkg::ADDR_EQ_STAT: begin
            rd_d[5:0] = eq_w[port_sel_q];
         end
         rpe_pkg::ADDR_MANUAL: begin
            rd_d[rpe_pkg::MAN_UPPER_LSB +: 3] = upper_q[port_sel_q];
            rd_d[rpe_pkg::MAN_MODE_BIT] = lock_mode_q[port_sel_q];
            rd_d[rpe_pkg::MAN_LOWER_LSB +: 3] = lower_q[port_sel_q];
            rd_d[rpe_pkg::MAN_BYPASS_BIT] = bypass_q[port_sel_q];
         end
         rpe_pkg::ADDR_LIMITS: begin
            rd_d[rpe_pkg::LIM_CEIL_LSB +: 4] = ceil_q[port_sel_q];
            rd_d[3:0] = floor_q[port_sel_q];
         end
         // Reserved offsets other than 0xD1, and unmapped offsets, read zero
         default: rd_d = 8'h00;
      endcase
   end

   // Read data register, held between reads
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         REG_RDATA <= 8'h00;
      end else if (REG_RD) begin
         REG_RDATA <= rd_d;
      end
   end

   // Restart bit never reads back as one
   a_restart_clear: assert property (@(posedge CORE_CLK)
      disable iff (!RESET_N)
      REG_RD && REG_ADDR == rpe_pkg::ADDR_SEQ_CTL
      |=> !REG_RDATA[rpe_pkg::SEQ_RESTART_BIT])
      else $error("restart bit read back as one");

   // Pulldown follows pin mode one cycle later
   a_pulldown_auto: assert property (@(posedge CORE_CLK)
      disable iff (!RESET_N)
      pd_dis_q == '0 && $stable(pd_dis_q)
      |=> PULLDOWN_EN == ~$past(PIN_OUTPUT_MODE))
      else $error("pulldown not automatic");

   // Disabled pulldown stays off for pin 0
   a_pulldown_off: assert property (@(posedge CORE_CLK)
      disable iff (!RESET_N)
      pd_dis_q[0] |=> !PULLDOWN_EN[0])
      else $error("disabled pulldown driven on");

   c_port_switch: cover property (@(posedge CORE_CLK)
      disable iff (!RESET_N)
      wr_at(rpe_pkg::ADDR_PORT_SEL) ##1 REG_RD);
endmodule

`default_nettype wire

/* verification/rpe_host.sv */
// Purpose: Register host model for the equalizer control block
// Assumes: One-cycle strobes, read data valid the cycle after
// Notes:   Strobes change just after the rising edge
`default_nettype none

module rpe_host (
   input  wire logic       clk,
   input  wire logic [7:0] rdata,
   output logic      [7:0] addr,
   output logic      [7:0] wdata,
   output logic            wr,
   output logic            rd
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle bus from time zero
   initial begin
      addr  = 8'h00;
      wdata = 8'h00;
      wr    = 1'b0;
      rd    = 1'b0;
   end

   // One write; per-port offsets land on the selected port
   task automatic wr_b(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask

   // One read; data taken once the answering edge has landed
   task automatic rd_b(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1 d = rdata;
   endtask
endmodule

`default_nettype wire

/* verification/tb_top.sv */
// Purpose: Self-checking bench for the equalizer control block
// Assumes: Relock base shortened to 8 cycles
// Notes:   Windows are sampled mid-step to tolerate edge slack
`default_nettype none

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int B = 8; // Shortened relock base
   logic        clk, rst_n, wr, rd;   // Clock, reset, strobes
   logic [7:0]  addr, wdata, rdata;   // Register port
   logic [1:0]  lraw, frm, lock, inj; // Per-port link signals
   logic [6:0]  pmode, pden;          // Pin mode, pulldown
   logic [11:0] eq;                   // Settings of both ports
   logic [7:0]  v, w, r;              // Scratch bytes
   int          seed, fail_count, checked;
   logic [7:0]  ra[11] = '{8'h4c, 8'hbd, 8'hbe, 8'hbf, 8'hd0,
                  8'hd1, 8'hd2, 8'hd3, 8'hd4, 8'hd5, 8'he0};
   logic [7:0]  re[11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                  8'h43, 8'h94, 8'h00, 8'h60, 8'hf2, 8'h00};

   rpe_ctrl #(.NUM_PORTS(2), .NUM_PINS(7), .RELOCK_BASE_CYC(B)) u_rpe_ctrl (
      .CORE_CLK(clk), .RESET_N(rst_n), .REG_ADDR(addr),
      .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
      .RX_LOCK_RAW(lraw), .BC_FRAME(frm), .PIN_OUTPUT_MODE(pmode),
      .EQ_SETTING(eq), .RX_LOCK(lock), .BC_ERR_INJECT(inj),
      .PULLDOWN_EN(pden));
   rpe_host u_rpe_host (.clk(clk), .rdata(rdata), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd));

   // Free-running clock
   initial clk = 1'b0;
   always #5 clk = ~clk;

   // Byte compare, counted
   task automatic chk(input string n, input logic [7:0] e,
                      input logic [7:0] g);
      checked++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic rchk(input string n, input logic [7:0] a,
                       input logic [7:0] e);
      u_rpe_host.rd_b(a, r);
      chk(n, e, r);
   endtask
   // Manual setting packs upper and lower fields
   function automatic logic [7:0] man(input logic [7:0] d);
      return {2'b00, d[7:5], d[3:1]};
   endfunction
   // One frame; pulse expected the cycle after
   task automatic frame(input logic e);
      @(posedge clk) frm <= 2'b01;
      @(posedge clk) frm <= 2'b00;
      #1 chk("inject", {7'h0, e}, {6'h0, inj});
   endtask
   task automatic close_out();
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // Hang guard, far beyond the expected run
   initial begin
      #200000;
      fail_count++;
      close_out();
   end

   // Main sequence
   initial begin
      seed = 89;
      fail_count = 0;
      checked = 0;
      rst_n = 1'b0;
      {lraw, frm, pmode} = '0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 11; i++) rchk("reset", ra[i], re[i]);
      // Reserved and status places ignore writes
      u_rpe_host.wr_b(8'hbd, 8'hff);
      u_rpe_host.wr_b(8'hd3, 8'hff);
      rchk("rsvd", 8'hbd, 8'h00);
      rchk("status", 8'hd3, 8'h00);
      // Restart per relock code, sample between steps two and three
      for (int c = 0; c < 3; c++) begin
         u_rpe_host.wr_b({c[2:0], 5'h1c}, 8'h00);
         u_rpe_host.wr_b(8'hd2, {c[2:0], 5'h1c});
         repeat (1 + (20 << c)) @(posedge clk);
         #1 chk("steps", 8'h04, {2'b0, eq[5:0]});
      end
      rchk("restart", 8'hd2, 8'h5c & 8'hf4);
      // Ceiling stops adaptation
      u_rpe_host.wr_b(8'hd5, 8'h32);
      u_rpe_host.wr_b(8'hd2, 8'h1c);
      repeat (60) @(posedge clk);
      #1 chk("ceiling", 8'h03, {2'b0, eq[5:0]});
      // First lock restarts at zero; detector-only lock lags one cycle
      @(posedge clk) lraw <= 2'b01;
      @(posedge clk) #1 chk("lock0", 8'h01, {6'h0, lock});
      repeat (2) @(posedge clk);
      #1 chk("firstlock", 8'h00, {2'b0, eq[5:0]});
      // Lock mode one waits for adaptation: two-cycle lag
      u_rpe_host.wr_b(8'hd4, 8'h70);
      @(posedge clk) lraw <= 2'b00;
      repeat (3) @(posedge clk);
      lraw <= 2'b01;
      @(posedge clk) #1 chk("lock1a", 8'h00, {6'h0, lock});
      @(posedge clk) #1 chk("lock1b", 8'h01, {6'h0, lock});
      // Restart, floor off, mode clear: lock lands at step two
      u_rpe_host.wr_b(8'hd2, 8'h08);
      lraw <= 2'b00;
      repeat (20) @(posedge clk);
      lraw <= 2'b01;
      repeat (3) @(posedge clk);
      #1 chk("keep", 8'h02, {2'b0, eq[5:0]});
      // Bypass on both ports through the port select
      v = $random(seed) | 8'h01;
      w = $random(seed) | 8'h01;
      u_rpe_host.wr_b(8'hd4, v);
      u_rpe_host.wr_b(8'h4c, 8'h01);
      u_rpe_host.wr_b(8'hd4, w);
      repeat (2) @(posedge clk);
      #1 chk("manual0", man(v), {2'b0, eq[5:0]});
      chk("manual1", man(w), {2'b0, eq[11:6]});
      rchk("port1", 8'hd4, w);
      // Single and continuous error injection on port 0
      u_rpe_host.wr_b(8'h4c, 8'h00);
      u_rpe_host.wr_b(8'hd0, 8'h01);
      frame(1'b1);
      frame(1'b0);
      u_rpe_host.wr_b(8'hd0, 8'h02);
      frame(1'b1);
      frame(1'b1);
      // Pulldown follows pin mode and disable bits
      for (int i = 0; i < 4; i++) begin
         v = $random(seed);
         @(posedge clk) pmode <= $random(seed);
         u_rpe_host.wr_b(8'hbe, v);
         repeat (2) @(posedge clk);
         chk("pulldown", {1'b0, ~pmode & ~v[6:0]}, {1'b0, pden});
         rchk("pdreg", 8'hbe, v & 8'h7f);
      end
      close_out();
   end
endmodule

`default_nettype wire
